//--- inc/drc_pkg.sv
// Constants and types for the run-command mode control block.
package drc_pkg;

    // ------------------------------------------------------------
    // Setting encodings
    // ------------------------------------------------------------
    localparam logic [1:0] ESC_FUNC_LOCAL_REMOTE = 2'h2;
    localparam logic [1:0] PREVENT_NONE          = 2'h0;
    localparam logic [1:0] PREVENT_FORWARD       = 2'h1;
    localparam logic [1:0] PREVENT_REVERSE       = 2'h2;
    localparam logic [2:0] CMD_SRC_KEYPAD        = 3'h0;
    localparam logic [2:0] CMD_SRC_TERMINAL_1    = 3'h1;
    localparam logic [2:0] CMD_SRC_TERMINAL_2    = 3'h2;
    localparam logic [5:0] FUNC_RUN_ENABLE       = 6'h0d;
    localparam int         SPEED_SEARCH_BIT      = 4;

    // ------------------------------------------------------------
    // Retry limits and timing
    // ------------------------------------------------------------
    localparam logic [3:0] RETRY_COUNT_MAX       = 4'ha;
    localparam logic [5:0] RETRY_DELAY_MAX_S     = 6'h3c;
    // Retry delay is set in tenths of a second; default 1.0 s.
    localparam logic [9:0] RETRY_DELAY_DEFAULT_DS = 10'h00a;
    localparam int         CLK_HZ                = 200_000_000;
    localparam int         TENTH_NS              = 100_000_000;
    localparam int         CLK_PERIOD_NS         = 1_000_000_000 / CLK_HZ;
    localparam int         TENTH_CYCLES          = TENTH_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Run states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_STOP,
        ST_SEARCH,
        ST_RUN,
        ST_DECEL,
        ST_TRIP,
        ST_RETRY_WAIT
    } drc_state_t;

endpackage

//--- design/drc_run_control.sv
// Run-command arbitration with local/remote switching, prevention and fault restart.
`timescale 1ns/1ps
`default_nettype none

module drc_run_control
    import drc_pkg::*;
#(
    parameter int INPUT_COUNT  = 5,
    parameter int TENTH_CYCLES_P = TENTH_CYCLES
) (
    input  wire logic                   core_clk_i,
    input  wire logic                   rst_i,
    input  wire logic [1:0]             escape_key_function_select_i,
    input  wire logic [2:0]             cmd_source_i,
    input  wire logic [1:0]             run_prevent_i,
    input  wire logic                   power_on_run_i,
    input  wire logic [7:0]             speed_search_options_i,
    input  wire logic                   fault_restart_enable_i,
    input  wire logic [3:0]             auto_retry_count_i,
    input  wire logic [9:0]             auto_retry_delay_i,
    input  wire logic [INPUT_COUNT-1:0] terminal_pin_i,
    input  wire logic [6*INPUT_COUNT-1:0] terminal_func_i,
    input  wire logic [5:0]             forward_run_input_sel_i,
    input  wire logic [5:0]             reverse_run_sel_i,
    input  wire logic [5:0]             fwd_jog_sel_i,
    input  wire logic [5:0]             rev_jog_sel_i,
    input  wire logic [5:0]             pre_excite_sel_i,
    input  wire logic                   escape_key_i,
    input  wire logic                   run_key_i,
    input  wire logic                   stop_key_i,
    input  wire logic                   rev_key_i,
    input  wire logic                   jog_key_i,
    input  wire logic                   serial_run_i,
    input  wire logic                   serial_stop_i,
    input  wire logic                   serial_rev_i,
    input  wire logic                   fault_trip_i,
    input  wire logic                   fault_reset_i,
    input  wire logic                   tripped_in_run_nv_i,
    output logic                        remote_mode_o,
    output logic                        set_lamp_flash_o,
    output logic                        output_enable_o,
    output logic                        run_o,
    output logic                        reverse_o,
    output logic                        jog_o,
    output logic                        speed_search_o,
    output logic                        decel_to_stop_o,
    output logic [3:0]                  retries_left_o
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [INPUT_COUNT-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_reg;
    logic                   esc_s1_reg, esc_s2_reg, esc_s3_reg, esc_level_reg, esc_press;

    // Terminal stages run through reset, so pins held at release are already seen as held.
    always_ff @(posedge core_clk_i) begin
        pin_s1_reg <= terminal_pin_i;
        pin_s2_reg <= pin_s1_reg;
        pin_s3_reg <= pin_s2_reg;
        pin_reg    <= (pin_s2_reg & pin_s3_reg) | (pin_reg & (pin_s2_reg | pin_s3_reg));
    end

    // Escape counts once second and third stages agree high after low.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            esc_s1_reg    <= 1'b0;
            esc_s2_reg    <= 1'b0;
            esc_s3_reg    <= 1'b0;
            esc_level_reg <= 1'b0;
        end else begin
            esc_s1_reg <= escape_key_i;
            esc_s2_reg <= esc_s1_reg;
            esc_s3_reg <= esc_s2_reg;
            if (esc_s2_reg == esc_s3_reg) begin
                esc_level_reg <= esc_s2_reg;
            end
        end
    end
    assign esc_press = esc_s2_reg && esc_s3_reg && !esc_level_reg;

    // ------------------------------------------------------------
    // Terminal function decode
    // ------------------------------------------------------------
    function automatic logic func_active(input logic [5:0] code,
                                         input logic [INPUT_COUNT-1:0] pins,
                                         input logic [6*INPUT_COUNT-1:0] funcs);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < INPUT_COUNT; i++) begin
            if (pins[i] && funcs[6*i +: 6] == code) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    logic t_fx, t_rx, t_fjog, t_rjog, t_pre, t_run_en, any_listed, terminal_src;
    assign t_fx       = func_active(forward_run_input_sel_i, pin_reg, terminal_func_i);
    assign t_rx       = func_active(reverse_run_sel_i, pin_reg, terminal_func_i);
    assign t_fjog     = func_active(fwd_jog_sel_i, pin_reg, terminal_func_i);
    assign t_rjog     = func_active(rev_jog_sel_i, pin_reg, terminal_func_i);
    assign t_pre      = func_active(pre_excite_sel_i, pin_reg, terminal_func_i);
    assign t_run_en   = func_active(FUNC_RUN_ENABLE, pin_reg, terminal_func_i);
    assign any_listed = t_fx | t_rx | t_fjog | t_rjog | t_pre;

    assign terminal_src = (cmd_source_i == CMD_SRC_TERMINAL_1) ||
                          (cmd_source_i == CMD_SRC_TERMINAL_2);

    // ------------------------------------------------------------
    // Local/remote mode
    // ------------------------------------------------------------
    logic toggle_en, toggle_en_reg, remote_reg, switched_local, switched_remote, powerup_reg;
    assign toggle_en = (escape_key_function_select_i == ESC_FUNC_LOCAL_REMOTE);

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            toggle_en_reg <= 1'b0;
            remote_reg    <= 1'b1;
            powerup_reg   <= 1'b1;
        end else begin
            toggle_en_reg <= toggle_en;
            powerup_reg   <= 1'b0;
            // Trip memory forces local at power-up.
            if (powerup_reg && toggle_en && tripped_in_run_nv_i) begin
                remote_reg <= 1'b0;
            end else if (toggle_en && !toggle_en_reg && !powerup_reg) begin
                remote_reg <= 1'b1;
            end else if (!toggle_en) begin
                remote_reg <= 1'b1;
            end else if (esc_press) begin
                remote_reg <= !remote_reg;
            end
        end
    end
    assign switched_local  = toggle_en && esc_press && remote_reg;
    assign switched_remote = toggle_en && esc_press && !remote_reg;

    // ------------------------------------------------------------
    // Terminal edge gate
    // ------------------------------------------------------------
    // The gate blocks terminal commands until every listed input has dropped.
    drc_state_t state_reg;
    logic [3:0] retries_reg;
    logic       term_block_reg, retry_ok;
    assign retry_ok = fault_restart_enable_i && terminal_src && retries_reg != 4'h0;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            term_block_reg <= 1'b1;
        // Block held inputs at power-up unless power-on run with a terminal source and no trip memory.
        end else if (powerup_reg) begin
            term_block_reg <= !(power_on_run_i && terminal_src) || tripped_in_run_nv_i;
        // Re-arm block after return to remote unless power-on run is set without trip memory.
        end else if (switched_remote && (!power_on_run_i || tripped_in_run_nv_i)) begin
            term_block_reg <= 1'b1;
        // A trip cleared without a retry needs the inputs to drop first.
        end else if (state_reg == ST_TRIP && fault_reset_i && !retry_ok) begin
            term_block_reg <= 1'b1;
        end else if (!any_listed) begin
            term_block_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Command selection
    // ------------------------------------------------------------
    logic want_run, want_rev, want_jog, local_mode;
    logic serial_latch_reg, serial_rev_reg, key_run_reg, key_rev_reg;
    assign local_mode = toggle_en && !remote_reg;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            serial_latch_reg <= 1'b0;
            serial_rev_reg   <= 1'b0;
            key_run_reg      <= 1'b0;
            key_rev_reg      <= 1'b0;
        end else if (switched_local || switched_remote) begin
            serial_latch_reg <= 1'b0;
            key_run_reg      <= 1'b0;
        end else begin
            if (serial_run_i) begin
                serial_latch_reg <= 1'b1;
                serial_rev_reg   <= serial_rev_i;
            end else if (serial_stop_i) begin
                serial_latch_reg <= 1'b0;
            end
            if (run_key_i) begin
                key_run_reg <= 1'b1;
            end else if (stop_key_i) begin
                key_run_reg <= 1'b0;
            end
            if (rev_key_i) begin
                key_rev_reg <= 1'b1;
            end else if (run_key_i) begin
                key_rev_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        want_run = 1'b0;
        want_rev = 1'b0;
        want_jog = 1'b0;
        if (local_mode) begin
            want_run = key_run_reg;
            want_rev = key_rev_reg;
            // Local jog gated by run enable.
            want_jog = jog_key_i && t_run_en;
        end else if (terminal_src) begin
            if (!term_block_reg) begin
                if (cmd_source_i == CMD_SRC_TERMINAL_1) begin
                    want_run = t_fx ^ t_rx;
                    want_rev = t_rx;
                end else begin
                    want_run = t_fx;
                    want_rev = t_rx;
                end
                want_jog = t_fjog || t_rjog;
                if (t_rjog && !want_run) begin
                    want_rev = 1'b1;
                end
            end
        end else if (cmd_source_i == CMD_SRC_KEYPAD) begin
            want_run = key_run_reg;
            want_rev = key_rev_reg;
        end else begin
            want_run = serial_latch_reg;
            want_rev = serial_rev_reg;
        end
    end

    logic prohibited, go;
    assign prohibited = (want_run || want_jog) &&
                        ((run_prevent_i == PREVENT_FORWARD && !want_rev) ||
                         (run_prevent_i == PREVENT_REVERSE && want_rev));

    // ------------------------------------------------------------
    // Run state machine and fault restart
    // ------------------------------------------------------------
    logic [9:0]  delay_ds_reg;
    logic [31:0] tick_reg;
    assign go = (want_run || want_jog) && !prohibited;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            tick_reg <= '0;
        end else if (state_reg != ST_RETRY_WAIT || tick_reg == 32'(TENTH_CYCLES_P - 1)) begin
            tick_reg <= '0;
        end else begin
            tick_reg <= tick_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_reg    <= ST_STOP;
            retries_reg  <= '0;
            delay_ds_reg <= '0;
        end else if (fault_trip_i) begin
            state_reg <= ST_TRIP;
        end else begin
            unique case (state_reg)
                ST_STOP: begin
                    if (go) begin
                        retries_reg <= (auto_retry_count_i > RETRY_COUNT_MAX) ?
                                       RETRY_COUNT_MAX : auto_retry_count_i;
                        state_reg <= speed_search_options_i[SPEED_SEARCH_BIT] ?
                                     ST_SEARCH : ST_RUN;
                    end
                end
                ST_SEARCH: begin
                    state_reg <= go ? ST_RUN : ST_STOP;
                end
                ST_RUN: begin
                    if (switched_local || (switched_remote && !terminal_src)) begin
                        state_reg <= ST_STOP;
                    end else if (prohibited || !go) begin
                        state_reg <= ST_DECEL;
                    end
                end
                ST_DECEL: begin
                    state_reg <= ST_STOP;
                end
                ST_TRIP: begin
                    if (fault_reset_i) begin
                        if (retry_ok) begin
                            state_reg    <= ST_RETRY_WAIT;
                            delay_ds_reg <= auto_retry_delay_i;
                        end else begin
                            state_reg <= ST_STOP;
                        end
                    end
                end
                ST_RETRY_WAIT: begin
                    if (delay_ds_reg == 10'h000) begin
                        retries_reg <= retries_reg - 4'h1;
                        state_reg   <= go ? (speed_search_options_i[SPEED_SEARCH_BIT] ?
                                             ST_SEARCH : ST_RUN) : ST_STOP;
                    end else if (tick_reg == 32'(TENTH_CYCLES_P - 1)) begin
                        delay_ds_reg <= delay_ds_reg - 10'h001;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            remote_mode_o    <= 1'b1;
            set_lamp_flash_o <= 1'b0;
            output_enable_o  <= 1'b0;
            run_o            <= 1'b0;
            reverse_o        <= 1'b0;
            jog_o            <= 1'b0;
            speed_search_o   <= 1'b0;
            decel_to_stop_o  <= 1'b0;
            retries_left_o   <= '0;
        end else begin
            remote_mode_o    <= !local_mode;
            set_lamp_flash_o <= local_mode;
            output_enable_o  <= state_reg == ST_RUN || state_reg == ST_SEARCH ||
                                state_reg == ST_DECEL;
            run_o            <= state_reg == ST_RUN && !want_jog;
            reverse_o        <= want_rev;
            jog_o            <= state_reg == ST_RUN && want_jog;
            speed_search_o   <= state_reg == ST_SEARCH;
            decel_to_stop_o  <= state_reg == ST_DECEL;
            retries_left_o   <= retries_reg;
        end
    end

endmodule

`default_nettype wire

//--- sim/drc_run_control_props.sv
// Concurrent checks on the ports of the run-command mode control block.
`timescale 1ns/1ps
`default_nettype none

module drc_run_control_props
    import drc_pkg::*;
#(
    parameter int INPUT_COUNT    = 5,
    parameter int TENTH_CYCLES_P = 4
) (
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic [1:0] escape_key_function_select_i,
    input  wire logic [1:0] run_prevent_i,
    input  wire logic [7:0] speed_search_options_i,
    input  wire logic       rev_key_i,
    input  wire logic       fault_trip_i,
    input  wire logic       remote_mode_o,
    input  wire logic       set_lamp_flash_o,
    input  wire logic       output_enable_o,
    input  wire logic       run_o,
    input  wire logic       reverse_o,
    input  wire logic       speed_search_o,
    input  wire logic       decel_to_stop_o,
    input  wire logic [3:0] retries_left_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence s_toggle_off;
        (escape_key_function_select_i != ESC_FUNC_LOCAL_REMOTE) [*3];
    endsequence

    sequence s_rev_banned;
        rev_key_i && !remote_mode_o && run_o && !reverse_o && run_prevent_i == PREVENT_REVERSE;
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    chk_toggle_off_remote: assert property (s_toggle_off |-> remote_mode_o)
        else $error("remote mode lost while the escape toggle is off");
    chk_lamp_in_local: assert property (set_lamp_flash_o == !remote_mode_o)
        else $error("set lamp does not match local mode");
    chk_local_stops_run: assert property ($fell(remote_mode_o) |-> ##[0:2] !run_o)
        else $error("run kept after switch to local");
    chk_start_dir_ok: assert property ($rose(run_o) |->
        (reverse_o ? run_prevent_i != PREVENT_REVERSE : run_prevent_i != PREVENT_FORWARD))
        else $error("start in a prohibited direction");
    chk_rev_key_decel: assert property (s_rev_banned |-> ##[1:3] decel_to_stop_o)
        else $error("prohibited reverse request did not decelerate");
    chk_search_gated: assert property (
        $rose(speed_search_o) |-> $past(speed_search_options_i[SPEED_SEARCH_BIT]))
        else $error("speed search without its option bit");
    chk_trip_cuts_output: assert property (fault_trip_i |-> ##2 !output_enable_o)
        else $error("output still enabled after trip");
    chk_retry_ceiling: assert property (retries_left_o <= RETRY_COUNT_MAX)
        else $error("retry count above its ceiling");
    chk_retry_step: assert property (retries_left_o < $past(retries_left_o) |->
        retries_left_o == $past(retries_left_o) - 4'h1)
        else $error("retry count dropped by more than one");
endmodule

bind drc_run_control drc_run_control_props #(
    .INPUT_COUNT   (INPUT_COUNT),
    .TENTH_CYCLES_P(TENTH_CYCLES_P)
) u_props (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .run_prevent_i(run_prevent_i),
    .escape_key_function_select_i(escape_key_function_select_i),
    .speed_search_options_i(speed_search_options_i), .rev_key_i(rev_key_i),
    .fault_trip_i(fault_trip_i), .remote_mode_o(remote_mode_o), .run_o(run_o),
    .set_lamp_flash_o(set_lamp_flash_o), .output_enable_o(output_enable_o),
    .reverse_o(reverse_o), .speed_search_o(speed_search_o),
    .decel_to_stop_o(decel_to_stop_o), .retries_left_o(retries_left_o)
);

`default_nettype wire

//--- sim/drc_panel_model.sv
// Model of the terminal block, keypad and serial host feeding the block.
`timescale 1ns/1ps
`default_nettype none

module drc_panel_model (
    input  wire logic       clk_i,
    input  wire logic [4:0] pin_req_i,
    input  wire logic [6:0] key_req_i,
    input  wire logic       esc_req_i,
    output logic      [4:0] terminal_pin_o,
    output logic      [6:0] key_o,
    output logic            escape_key_o
);
    logic [6:0] key_prev_reg;

    initial begin
        terminal_pin_o = 5'h00;
        key_o = 7'h00;
        escape_key_o = 1'b0;
        key_prev_reg = 7'h00;
    end

    // A held key request gives one pulse; the jog key is a level.
    always @(negedge clk_i) begin
        terminal_pin_o <= pin_req_i;
        escape_key_o <= esc_req_i;
        key_prev_reg <= key_req_i;
        key_o <= (key_req_i & ~key_prev_reg & 7'h77) | (key_req_i & 7'h08);
    end
endmodule

`default_nettype wire

//--- sim/drc_run_control_tb.sv
// Self-checking bench for the run-command mode control block.
`timescale 1ns/1ps
`default_nettype none

module drc_run_control_tb
    import drc_pkg::*;
;
    localparam int TC = 4;
    logic        core_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [1:0]  escape_key_function_select_i = 2'h0;
    logic [2:0]  cmd_source_i = CMD_SRC_KEYPAD;
    logic [1:0]  run_prevent_i = PREVENT_NONE;
    logic        power_on_run_i = 1'b0;
    logic [7:0]  speed_search_options_i = 8'h00;
    logic        fault_restart_enable_i = 1'b0;
    logic [3:0]  auto_retry_count_i = 4'h0;
    logic [9:0]  auto_retry_delay_i = RETRY_DELAY_DEFAULT_DS;
    logic [29:0] terminal_func_i = {6'h3f, 6'h3f, FUNC_RUN_ENABLE, 6'h02, 6'h01};
    logic        fault_trip_i = 1'b0, fault_reset_i = 1'b0, tripped_in_run_nv_i = 1'b0;
    logic [4:0]  pin_req = 5'h00, terminal_pin_i;
    logic [6:0]  key_req = 7'h00, keys;
    logic        esc_req = 1'b0, escape_key_i;
    logic        remote_mode_o, set_lamp_flash_o, output_enable_o, run_o, reverse_o, jog_o;
    logic        speed_search_o, decel_to_stop_o, saw_search = 1'b0, saw_decel = 1'b0;
    logic [3:0]  retries_left_o;
    logic [5:0]  pre_sel = 6'h0c;
    int          failures = 0, checked = 0, cycles = 0, n, d;

    always #2.5 core_clk_i = ~core_clk_i;

    drc_panel_model u_panel (.clk_i(core_clk_i), .pin_req_i(pin_req), .key_req_i(key_req),
        .esc_req_i(esc_req), .terminal_pin_o(terminal_pin_i), .key_o(keys),
        .escape_key_o(escape_key_i));

    drc_run_control #(.INPUT_COUNT(5), .TENTH_CYCLES_P(TC)) DUT (
        .core_clk_i, .rst_i, .escape_key_function_select_i, .cmd_source_i, .run_prevent_i,
        .power_on_run_i, .speed_search_options_i, .fault_restart_enable_i,
        .auto_retry_count_i, .auto_retry_delay_i, .terminal_pin_i, .terminal_func_i,
        .forward_run_input_sel_i(6'h01), .reverse_run_sel_i(6'h02), .fwd_jog_sel_i(6'h06),
        .rev_jog_sel_i(6'h07), .pre_excite_sel_i(pre_sel), .escape_key_i,
        .run_key_i(keys[0]), .stop_key_i(keys[1]), .rev_key_i(keys[2]), .jog_key_i(keys[3]),
        .serial_run_i(keys[4]), .serial_stop_i(keys[5]), .serial_rev_i(keys[6]),
        .fault_trip_i, .fault_reset_i, .tripped_in_run_nv_i, .remote_mode_o,
        .set_lamp_flash_o, .output_enable_o, .run_o, .reverse_o, .jog_o, .speed_search_o,
        .decel_to_stop_o, .retries_left_o);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] exp_run(input int code);
        return (code == PREVENT_NONE) ? 4'h1 : 4'h0;
    endfunction

    function automatic logic [3:0] exp_left(input int total, input int k);
        return (k <= total) ? 4'(total - k) : 4'h0;
    endfunction

    task automatic step(input int k);
        repeat (k) @(negedge core_clk_i);
    endtask

    task automatic press(input int i);
        key_req[i] <= 1'b1;
        step(1);
        key_req[i] <= 1'b0;
        step(5);
    endtask

    task automatic esc();
        esc_req <= 1'b1;
        step(10);
        esc_req <= 1'b0;
        step(10);
    endtask

    // Unused pins 3 and 4 carry random noise; their function code is unassigned.
    task automatic pins(input logic [4:0] v);
        pin_req <= v | (5'($urandom()) & 5'h18);
        step(10);
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        step(12);
        rst_i <= 1'b0;
        step(10);
    endtask

    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge core_clk_i) begin
        cycles++;
        if (speed_search_o === 1'b1) saw_search = 1'b1;
        if (decel_to_stop_o === 1'b1) saw_decel = 1'b1;
        if (cycles == 20000) begin
            failures++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h886f));
        n = 2 + $urandom_range(2);
        d = 1 + $urandom_range(2);
        do_reset();
        check(remote_mode_o, 4'h1);
        check(output_enable_o, 4'h0);
        press(0);
        check(run_o, 4'h1);
        check(remote_mode_o, 4'h1);
        escape_key_function_select_i <= ESC_FUNC_LOCAL_REMOTE;
        step(3);
        check(remote_mode_o, 4'h1);
        check(run_o, 4'h1);
        esc();
        check({set_lamp_flash_o, remote_mode_o}, 4'h2);
        check(run_o, 4'h0);
        for (int s = 0; s < 2; s++) begin
            cmd_source_i <= (s == 0) ? CMD_SRC_KEYPAD : 3'h3;
            press(0);
            check(run_o, 4'h1);
            esc();
            check({set_lamp_flash_o, remote_mode_o}, 4'h1);
            check(run_o, 4'h0);
            press(s * 4);
            check(run_o, 4'h1);
            press(s * 4 + 1);
            esc();
        end
        cmd_source_i <= CMD_SRC_KEYPAD;
        for (int c = 0; c < 3; c++) begin
            run_prevent_i <= 2'(c);
            saw_decel = 1'b0;
            press(0);
            if (c != 1) press(2);
            check(run_o, exp_run(c));
            if (c == 2) check(saw_decel, 4'h1);
            press(1);
        end
        run_prevent_i <= PREVENT_NONE;
        terminal_func_i[17:12] <= 6'h3f;
        pins(5'h04);
        key_req[3] <= 1'b1;
        step(6);
        check(jog_o, 4'h0);
        terminal_func_i[17:12] <= FUNC_RUN_ENABLE;
        step(6);
        check(jog_o, 4'h1);
        key_req[3] <= 1'b0;
        escape_key_function_select_i <= 2'h0;
        cmd_source_i <= CMD_SRC_TERMINAL_1;
        pins(5'h01);
        do_reset();
        check(run_o, 4'h0);
        pins(5'h00);
        pins(5'h01);
        check({reverse_o, run_o}, 4'h1);
        pins(5'h03);
        check(run_o, 4'h0);
        power_on_run_i <= 1'b1;
        pins(5'h02);
        do_reset();
        check({reverse_o, run_o}, 4'h3);
        escape_key_function_select_i <= ESC_FUNC_LOCAL_REMOTE;
        esc();
        check(run_o, 4'h0);
        esc();
        check({reverse_o, run_o}, 4'h3);
        cmd_source_i <= CMD_SRC_TERMINAL_2;
        pins(5'h03);
        check({reverse_o, run_o}, 4'h3);
        pins(5'h00);
        speed_search_options_i <= 8'h10;
        saw_search = 1'b0;
        pins(5'h01);
        check(saw_search, 4'h1);
        pins(5'h00);
        speed_search_options_i <= 8'h00;
        saw_search = 1'b0;
        pins(5'h01);
        check({saw_search, run_o}, 4'h1);
        fault_restart_enable_i <= 1'b1;
        auto_retry_count_i <= 4'(n);
        auto_retry_delay_i <= 10'(d);
        // A fresh start loads the retry budget.
        pins(5'h00);
        pins(5'h01);
        for (int k = 1; k <= n + 1; k++) begin
            fault_trip_i <= 1'b1;
            step(1);
            fault_trip_i <= 1'b0;
            step(3);
            check(output_enable_o, 4'h0);
            fault_reset_i <= 1'b1;
            step(1);
            fault_reset_i <= 1'b0;
            step(d * TC - 3);
            check(run_o, 4'h0);
            step(12);
            check(run_o, 4'(k <= n));
            check(retries_left_o, exp_left(n, k));
        end
        fault_restart_enable_i <= 1'b0;
        power_on_run_i <= 1'b0;
        tripped_in_run_nv_i <= 1'b1;
        do_reset();
        check(remote_mode_o, 4'h0);
        esc();
        check({remote_mode_o, run_o}, 4'h2);
        pins(5'h00);
        pins(5'h01);
        check(run_o, 4'h1);
        end_sim();
    end
endmodule

`default_nettype wire
